// *** core/omc_pkg.sv ***
// omc_pkg: constants shared by the module management control logic
// assumes: one 50 MHz clock mclk, synchronous active-high reset rst
// Overview of operation
// - serial commands answered only while deselect low
// - active-low interrupt flags readable condition details
// - laser disable input turns transmitter laser off
// - not-ready is OR of signal-lost and lock-loss
// - signal-lost low when normal, high without signal
// - module-absent output held low inside module
// - power-down high holds module in standby
// - power-down falling edge starts module reset
// - that reset also reinitialises the serial interface
// - reference clock input is ignored
// - write data on rising clock, unprotected only
// - read data launched on falling serial clock
// - start and stop conditions framed, detected here
// - byte memory from 000h, random and sequential
// - monitored values kept current and readable
// - alarm and warning flags when out of range
package omc_pkg;
  localparam int          MEM_AW        = 8;
  localparam int          MEM_DEPTH     = 256;
  localparam logic [6:0]  DEV_ADDR      = 7'h50;
  // monitor value bytes, high byte then low byte
  localparam logic [7:0]  A_TEMP        = 8'h60;
  localparam logic [7:0]  A_BIAS        = 8'h64;
  localparam logic [7:0]  A_TXPWR       = 8'h66;
  localparam logic [7:0]  A_RXPWR       = 8'h68;
  localparam logic [7:0]  A_VCC         = 8'h6A;
  // flag bytes, clear on read
  localparam logic [7:0]  A_ALARM       = 8'h50;
  localparam logic [7:0]  A_WARN        = 8'h52;
  // threshold table: per channel hi alarm, lo alarm, hi warn, lo warn
  localparam logic [7:0]  A_THRESH      = 8'h00;
  // write protection: bytes up to and including this, live area among them, are read only
  localparam logic [7:0]  A_WR_LOW      = 8'h7F;
  localparam logic [7:0]  A_LIVE_LO     = 8'h50;
  localparam logic [7:0]  A_LIVE_HI     = 8'h6F;
  // factory thresholds, plain defaults, reloaded by every reset
  localparam logic [15:0] TH_HI_ALM     = 16'hF000;
  localparam logic [15:0] TH_LO_ALM     = 16'h1000;
  localparam logic [15:0] TH_HI_WRN     = 16'hE000;
  localparam logic [15:0] TH_LO_WRN     = 16'h2000;
  localparam int          N_MON         = 5;
  // power-down reset pulse length
  localparam int          RST_NS        = 200;
  localparam int          CLK_NS        = 20;
  localparam int          RST_CYC       = (RST_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [3:0] {
    OMC_IDLE = 4'b0001,
    OMC_ADDR = 4'b0010,
    OMC_WR   = 4'b0100,
    OMC_RD   = 4'b1000
  } omc_st_e;
endpackage

// *** core/omc_sync.sv ***
// omc_sync: two flip-flop level synchroniser
// assumes: input asynchronous to mclk
`timescale 1ns/1ps
module omc_sync (
  // clock
  input  wire logic mclk,
  input  wire logic rst,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// *** core/omc_i2c.sv ***
// omc_i2c: two-wire slave byte engine, events to the memory side
// assumes: scl and sda already synchronised to mclk
`timescale 1ns/1ps
module omc_i2c
  import omc_pkg::*;
(
  // clock
  input  wire logic       mclk,
  input  wire logic       srst,
  // synchronised pins
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  input  wire logic       sel,
  // memory side
  output logic [7:0]      mem_addr,
  output logic            mem_we,
  output logic [7:0]      mem_wdata,
  output logic            mem_re,
  input  wire logic [7:0] mem_rdata,
  // data pin drive
  output logic            sda_oe
);
  omc_st_e     st_reg;
  logic        scl_d_reg;
  logic        sda_d_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  cnt_reg;
  logic        ack_reg;
  logic        first_reg;
  logic [7:0]  out_reg;
  wire         scl_rise = scl_s & ~scl_d_reg;
  wire         scl_fall = ~scl_s & scl_d_reg;
  // framing conditions: data moves while clock high
  wire         start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire         stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire         byte_end = (cnt_reg == 4'd8);
  wire [7:0]   sh_next  = {sh_reg[6:0], sda_s};
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  always_ff @(posedge mclk) begin
    mem_we <= 1'b0;
    mem_re <= 1'b0;
    if (srst || !sel) begin // traffic ignored while deselected
      st_reg    <= OMC_IDLE;
      cnt_reg   <= 4'd0;
      ack_reg   <= 1'b0;
      sda_oe    <= 1'b0;
      sh_reg    <= 8'h00;
      first_reg <= 1'b0;
      out_reg   <= 8'h00;
      mem_addr  <= 8'h00;
      mem_wdata <= 8'h00;
    end else if (start_c) begin
      st_reg  <= OMC_ADDR;
      cnt_reg <= 4'd0;
      ack_reg <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (stop_c) begin
      st_reg <= OMC_IDLE;
      sda_oe <= 1'b0;
    end else if (st_reg != OMC_IDLE) begin
      if (scl_rise) begin
        if (ack_reg) begin
          // master nack ends a read
          if (st_reg == OMC_RD && sda_s)
            st_reg <= OMC_IDLE;
        end else if (!(st_reg == OMC_RD)) begin
          // capture on rising clock
          sh_reg  <= sh_next;
          cnt_reg <= cnt_reg + 4'd1;
        end else begin
          cnt_reg <= cnt_reg + 4'd1;
        end
      end else if (scl_fall) begin
        // all drive changes on falling clock
        if (ack_reg) begin
          ack_reg <= 1'b0;
          cnt_reg <= 4'd0;
          if (st_reg == OMC_RD) begin
            sda_oe  <= ~mem_rdata[7];
            out_reg <= {mem_rdata[6:0], 1'b0};
            mem_re  <= 1'b1;
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (byte_end) begin
          ack_reg <= 1'b1;
          case (st_reg)
            OMC_ADDR: begin
              if (sh_reg[7:1] == DEV_ADDR) begin
                sda_oe <= 1'b1;
                first_reg <= 1'b1;
                st_reg <= sh_reg[0] ? OMC_RD : OMC_WR;
              end else begin
                st_reg <= OMC_IDLE;
                sda_oe <= 1'b0;
              end
            end
            OMC_WR: begin
              sda_oe <= 1'b1;
              if (first_reg) begin
                mem_addr  <= sh_reg;
                first_reg <= 1'b0;
              end else begin
                mem_wdata <= sh_reg;
                mem_we    <= 1'b1;
              end
            end
            OMC_RD: sda_oe <= 1'b0;
            default: st_reg <= OMC_IDLE;
          endcase
        end else if (st_reg == OMC_RD) begin
          sda_oe  <= ~out_reg[7];
          out_reg <= {out_reg[6:0], 1'b0};
        end
      end
    end
    // the address pointer steps after each data byte written or fetched for reading
    if (!srst && sel && (mem_we || mem_re))
      mem_addr <= mem_addr + 8'h01;
  end
endmodule

// *** core/omc_top.sv ***
// omc_top: management pins, byte memory and diagnostics monitor
// assumes: host pulls up open-drain lines; adc values arrive on mclk
`timescale 1ns/1ps
module omc_top
  import omc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // host control pins
  input  wire logic        deselect,
  input  wire logic        laser_off_request,
  input  wire logic        power_down,
  input  wire logic        ref_clock_in_p,
  // two-wire bus
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // optics status from the analog front end
  input  wire logic        rx_no_light,
  input  wire logic        tx_lock_lost,
  input  wire logic        rx_lock_lost,
  // monitor samples, 16 bits each
  input  wire logic [15:0] mon_temp,
  input  wire logic [15:0] mon_bias,
  input  wire logic [15:0] mon_txpwr,
  input  wire logic [15:0] mon_rxpwr,
  input  wire logic [15:0] mon_vcc,
  // status and control outputs
  output logic             interrupt_n,
  output logic             not_ready_flag,
  output logic             rx_signal_lost,
  output logic             module_absent,
  output logic             laser_enable,
  output logic             standby
);
  logic        desel_s;
  logic        txdis_s;
  logic        pd_s;
  logic        scl_s;
  logic        sda_s;
  logic        los_s;
  logic        txl_s;
  logic        rxl_s;
  logic        pd_d_reg;
  logic [3:0]  prst_cnt_reg;
  logic [7:0]  mem [0:MEM_DEPTH-1];
  logic [7:0]  alarm_reg;
  logic [7:0]  warn_reg;
  wire  [7:0]  mem_addr;
  wire         mem_we;
  wire  [7:0]  mem_wdata;
  wire         mem_re;
  logic [7:0]  mem_rdata;
  wire         sda_drive;

  // all host pins are asynchronous; link data and clock included
  wire [7:0] raw_in = {deselect, laser_off_request, power_down, scl,
                       sda_in, rx_no_light, tx_lock_lost, rx_lock_lost};
  wire [7:0] syn_out;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      omc_sync u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    (raw_in[gi]),
        .q    (syn_out[gi])
      );
    end
  endgenerate
  assign {desel_s, txdis_s, pd_s, scl_s, sda_s, los_s, txl_s, rxl_s}
    = syn_out;

  // falling edge of power-down starts an internal reset
  wire pd_fall  = pd_d_reg & ~pd_s;
  wire prst_act = (prst_cnt_reg != 4'd0);
  // internal reset covers the serial engine and flags
  wire srst     = rst | prst_act | pd_fall;
  always_ff @(posedge mclk) begin
    if (rst) begin
      pd_d_reg     <= 1'b0;
      prst_cnt_reg <= 4'd0;
    end else begin
      pd_d_reg <= pd_s;
      if (pd_fall)
        prst_cnt_reg <= 4'(RST_CYC);
      else if (prst_act)
        prst_cnt_reg <= prst_cnt_reg - 4'd1;
    end
  end

  // ref_clock_in_p deliberately unused; nothing depends on it
  wire unused_ref = ref_clock_in_p;

  omc_i2c u_i2c (
    .mclk      (mclk),
    .srst      (srst | pd_s),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .sel       (~desel_s),
    .mem_addr  (mem_addr),
    .mem_we    (mem_we),
    .mem_wdata (mem_wdata),
    .mem_re    (mem_re),
    .mem_rdata (mem_rdata),
    .sda_oe    (sda_drive)
  );

  // only the user area may be written
  wire wr_ok = mem_we && (mem_addr > A_WR_LOW);

  // compare a 16-bit sample against its four thresholds
  function automatic logic [3:0] range_chk(input logic [15:0] v,
                                           input logic [7:0] base);
    logic [15:0] ha;
    logic [15:0] la;
    logic [15:0] hw;
    logic [15:0] lw;
    ha = {mem[base], mem[base + 8'h01]};
    la = {mem[base + 8'h02], mem[base + 8'h03]};
    hw = {mem[base + 8'h04], mem[base + 8'h05]};
    lw = {mem[base + 8'h06], mem[base + 8'h07]};
    range_chk = {v > ha, v < la, v > hw, v < lw};
  endfunction

  wire [15:0] mon_v [0:N_MON-1];
  assign mon_v[0] = mon_temp;
  assign mon_v[1] = mon_bias;
  assign mon_v[2] = mon_txpwr;
  assign mon_v[3] = mon_rxpwr;
  assign mon_v[4] = mon_vcc;
  wire [7:0] mon_a [0:N_MON-1];
  assign mon_a[0] = A_TEMP;
  assign mon_a[1] = A_BIAS;
  assign mon_a[2] = A_TXPWR;
  assign mon_a[3] = A_RXPWR;
  assign mon_a[4] = A_VCC;

  // thresholds sit at A_THRESH + 8*channel (factory area)
  wire [3:0] chk [0:N_MON-1];
  wire [7:0] thr_a [0:N_MON-1];
  wire [7:0] alarm_ev;
  wire [7:0] warn_ev;
  generate
    for (gi = 0; gi < N_MON; gi++) begin : g_chk
      assign thr_a[gi] = A_THRESH + 8'(gi * 8);
      assign chk[gi] = range_chk(mon_v[gi], thr_a[gi]);
      assign alarm_ev[gi] = chk[gi][3] | chk[gi][2];
      assign warn_ev[gi]  = chk[gi][1] | chk[gi][0];
    end
  endgenerate
  assign alarm_ev[7:N_MON] = '0;
  assign warn_ev[7:N_MON]  = '0;

  wire rd_alarm = mem_re && (mem_addr == A_ALARM);
  wire rd_warn  = mem_re && (mem_addr == A_WARN);

  // live values, flags, else storage
  always_comb begin
    mem_rdata = mem[mem_addr];
    if (mem_addr == A_ALARM)
      mem_rdata = alarm_reg;
    else if (mem_addr == A_WARN)
      mem_rdata = warn_reg;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      // thresholds reload as after power-up, never left unknown
      for (int i = 0; i < N_MON; i++) begin
        {mem[thr_a[i]], mem[thr_a[i] + 8'h01]}         <= TH_HI_ALM;
        {mem[thr_a[i] + 8'h02], mem[thr_a[i] + 8'h03]} <= TH_LO_ALM;
        {mem[thr_a[i] + 8'h04], mem[thr_a[i] + 8'h05]} <= TH_HI_WRN;
        {mem[thr_a[i] + 8'h06], mem[thr_a[i] + 8'h07]} <= TH_LO_WRN;
      end
    end else if (wr_ok) begin
      mem[mem_addr] <= mem_wdata;
    end
    // live monitor values refreshed every cycle
    for (int i = 0; i < N_MON; i++) begin
      mem[mon_a[i]]        <= mon_v[i][15:8];
      mem[mon_a[i] + 8'h01] <= mon_v[i][7:0];
    end
  end

  // sticky flags, set wins over clear-on-read
  always_ff @(posedge mclk) begin
    if (srst) begin
      alarm_reg <= 8'h00;
      warn_reg  <= 8'h00;
    end else begin
      alarm_reg <= (rd_alarm ? 8'h00 : alarm_reg) | alarm_ev;
      warn_reg  <= (rd_warn  ? 8'h00 : warn_reg)  | warn_ev;
    end
  end

  wire int_next = |{alarm_reg, warn_reg};

  always_ff @(posedge mclk) begin
    if (rst) begin
      interrupt_n    <= 1'b1;
      not_ready_flag <= 1'b0;
      rx_signal_lost <= 1'b0;
      module_absent  <= 1'b0;
      laser_enable   <= 1'b0;
      standby        <= 1'b0;
      sda_out        <= 1'b0;
      sda_oe         <= 1'b0;
    end else begin
      interrupt_n    <= ~int_next;
      not_ready_flag <= los_s | txl_s | rxl_s;
      rx_signal_lost <= los_s;
      module_absent  <= 1'b0;
      // srst holds pd_fall too: no one-cycle flash as reset starts
      laser_enable   <= ~txdis_s & ~pd_s & ~srst;
      standby        <= pd_s;
      sda_out        <= 1'b0; // open drain, only pulls low
      // module drives data only; serial clock is input
      sda_oe         <= sda_drive;
    end
  end
endmodule

// *** sim/omc_checker.sv ***
// omc_checker: timing of status pins and bus drive of omc_top
// assumes: bound to omc_top; pins reach outputs after 3 mclk edges
`timescale 1ns/1ps
module omc_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // host pins
  input wire logic deselect,
  input wire logic laser_off_request,
  input wire logic power_down,
  input wire logic scl,
  input wire logic rx_no_light,
  input wire logic tx_lock_lost,
  input wire logic rx_lock_lost,
  // module outputs
  input wire logic sda_oe,
  input wire logic interrupt_n,
  input wire logic not_ready_flag,
  input wire logic rx_signal_lost,
  input wire logic module_absent,
  input wire logic laser_enable,
  input wire logic standby
);
  logic [2:0] up_reg;
  logic       ok;
  // $past looks across reset, so wait for the synchronisers to refill
  always_ff @(posedge mclk)
    if (rst)
      up_reg <= 3'h0;
    else if (!ok)
      up_reg <= up_reg + 3'h1;
  assign ok = (up_reg == 3'h7);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  not_ready_a: assert property (ok |-> not_ready_flag ==
    ($past(rx_no_light, 3) | $past(tx_lock_lost, 3) |
     $past(rx_lock_lost, 3)))
    else $error("not ready flag off its fault inputs");
  sig_lost_a: assert property (ok |->
    rx_signal_lost == $past(rx_no_light, 3))
    else $error("signal lost output off its input");
  absent_low_a: assert property (!module_absent)
    else $error("module absent output high");
  laser_off_a: assert property (ok &&
    $past(laser_off_request, 3) |-> !laser_enable)
    else $error("laser on while disabled");
  standby_mode_a: assert property (ok |->
    standby == $past(power_down, 3))
    else $error("standby off the power down pin");
  pd_reset_a: assert property (ok && $fell(power_down) |->
    !laser_enable [*8])
    else $error("laser on during power down reset");
  pd_bus_a: assert property (ok && $fell(power_down) |->
    ##2 !sda_oe [*8])
    else $error("data line driven during reset");
  desel_quiet_a: assert property (deselect [*6] |-> !sda_oe)
    else $error("data line driven while deselected");
  oe_edge_a: assert property (ok && $changed(sda_oe) |->
    !$past(scl, 3))
    else $error("data drive changed while clock high");
  int_reset_a: assert property ($past(rst) |-> interrupt_n)
    else $error("interrupt asserted out of reset");
  cover property ($rose(sda_oe));
  cover property ($fell(power_down));
  cover property ($rose(not_ready_flag));
  cover property ($fell(interrupt_n));
endmodule

// *** sim/omc_host.sv ***
// omc_host: host board master driving the two-wire bus
// assumes: board pull-up on sda; one bit takes 8 mclk, 160 ns
`timescale 1ns/1ps
module omc_host (
  // clock
  input  wire logic mclk,
  // bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // only the host clocks the bus; scl rests high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (2) @(posedge mclk);
  endtask
  // extra wait lets the module drop its ack before scl rises
  task automatic start();
    sda_low <= 1'b0;
    q();
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
    q();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic put(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], r);
    clk_bit(1'b1, nak);
  endtask
  task automatic get(input logic nak, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      b = {b[6:0], r};
    end
    clk_bit(nak, r);
  endtask
endmodule

// *** sim/test_omc_top.sv ***
// test_omc_top: self-checking bench for omc_top with a host model
// assumes: omc_pkg, omc_top, omc_host and omc_checker compiled first
`timescale 1ns/1ps
module test_omc_top;
  import omc_pkg::*;
  localparam logic [7:0] MA [N_MON] = '{A_TEMP, A_BIAS, A_TXPWR,
                                        A_RXPWR, A_VCC};
  // one sample in each out-of-range band
  localparam logic [15:0] OUT_V [4] = '{16'hF800, 16'hE800, 16'h0800,
                                        16'h1800};
  logic        mclk, rst, deselect, laser_off_request, power_down;
  logic        ref_clock_in_p, rx_no_light, tx_lock_lost, rx_lock_lost;
  logic [15:0] mon [N_MON];
  logic        scl, sda_in, sda_out, sda_oe, h_low, interrupt_n;
  logic        not_ready_flag, rx_signal_lost, module_absent;
  logic        laser_enable, standby;
  int          n_errors, checks_done;
  // open-drain data line with the board pull-up
  assign sda_in = !(h_low | (sda_oe & !sda_out));
  omc_top uut (.mclk, .rst, .deselect, .laser_off_request, .power_down,
    .ref_clock_in_p, .scl, .sda_in, .sda_out, .sda_oe, .rx_no_light,
    .tx_lock_lost, .rx_lock_lost, .mon_temp(mon[0]), .mon_bias(mon[1]),
    .mon_txpwr(mon[2]), .mon_rxpwr(mon[3]), .mon_vcc(mon[4]),
    .interrupt_n, .not_ready_flag, .rx_signal_lost, .module_absent,
    .laser_enable, .standby);
  omc_host u_host (.mclk, .sda(sda_in), .scl, .sda_low(h_low));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // expected {alarm, warn} for one sample against the defaults
  function automatic logic [1:0] exp_aw(logic [15:0] s);
    exp_aw = {(s > TH_HI_ALM) || (s < TH_LO_ALM),
              (s > TH_HI_WRN) || (s < TH_LO_WRN)};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic probe(logic [6:0] da, output logic k);
    u_host.start();
    u_host.put({da, 1'b0}, k);
    u_host.stop();
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    logic k;
    u_host.start();
    u_host.put({DEV_ADDR, 1'b0}, k);
    chk("write ack", 1'h0, k);
    u_host.put(a, k);
    u_host.put(d[15:8], k);
    u_host.put(d[7:0], k);
    u_host.stop();
  endtask
  // pointer write, repeated start, then two sequential bytes
  task automatic rd(logic [7:0] a, output logic [15:0] v);
    logic k;
    u_host.start();
    u_host.put({DEV_ADDR, 1'b0}, k);
    u_host.put(a, k);
    u_host.start();
    u_host.put({DEV_ADDR, 1'b1}, k);
    u_host.get(1'b0, v[15:8]);
    u_host.get(1'b1, v[7:0]);
    u_host.stop();
  endtask
  // single byte read; the byte after a flag byte is not defined
  task automatic rd_flag(logic [7:0] a, output logic [7:0] b);
    logic k;
    u_host.start();
    u_host.put({DEV_ADDR, 1'b0}, k);
    u_host.put(a, k);
    u_host.start();
    u_host.put({DEV_ADDR, 1'b1}, k);
    u_host.get(1'b1, b);
    u_host.stop();
  endtask
  initial begin
    logic [15:0] v, w, p;
    logic [2:0]  f;
    logic [7:0]  b;
    logic [1:0]  e;
    int          ch;
    logic        k;
    n_errors = 0;
    checks_done = 0;
    {rst, deselect, laser_off_request, power_down} = 4'hF;
    power_down = 1'b0;
    deselect = 1'b0;
    laser_off_request = 1'b0;
    {ref_clock_in_p, rx_no_light, tx_lock_lost, rx_lock_lost} = 4'h0;
    for (int c = 0; c < N_MON; c++)
      mon[c] = 16'h8000;
    void'($urandom(32'hD045790D));
    cyc(12);
    rst <= 1'b0;
    cyc(4);
    chk("absent", 1'h0, module_absent);
    // all eight fault codes, then random ones; ref clock toggles freely
    for (int i = 0; i < 12; i++) begin
      f = (i < 8) ? i[2:0] : 3'($urandom);
      {rx_no_light, tx_lock_lost, rx_lock_lost} <= f;
      laser_off_request <= f[0];
      ref_clock_in_p <= 1'($urandom);
      cyc(4);
      chk("not ready", 16'(|f), not_ready_flag);
      chk("signal lost", 16'(f[2]), rx_signal_lost);
      chk("laser", 16'(!f[0]), laser_enable);
    end
    laser_off_request <= 1'b0;
    $display("test pins done");
    for (int c = 0; c < N_MON; c++) begin
      mon[c] <= 16'($urandom);
      cyc(4);
      rd(MA[c], v);
      chk("monitor", mon[c], v);
    end
    $display("test monitors done");
    w = 16'($urandom);
    wr(8'h80, w);
    rd(8'h80, v);
    chk("ram", w, v);
    rd(8'h10, p);
    chk("threshold", TH_HI_ALM, p);
    wr(8'h10, ~p);
    rd(8'h10, v);
    chk("protected", p, v);
    $display("test memory done");
    // deselected with the right address, then selected with a wrong one
    for (int i = 0; i < 2; i++) begin
      deselect <= !i[0];
      cyc(4);
      probe(DEV_ADDR ^ 7'(i), k);
      chk("refused ack", 1'h1, k);
    end
    deselect <= 1'b0;
    $display("test refusal done");
    // each band on a random channel; flags stick until read
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < N_MON; c++)
        mon[c] <= 16'h8000;
      cyc(4);
      rd_flag(A_ALARM, b);
      rd_flag(A_WARN, b);
      cyc(4);
      chk("interrupt idle", 1'h1, interrupt_n);
      ch = int'($urandom % N_MON);
      mon[ch] <= OUT_V[i];
      e = exp_aw(OUT_V[i]);
      cyc(4);
      mon[ch] <= 16'h8000;
      cyc(4);
      chk("interrupt", 1'h0, interrupt_n);
      rd_flag(A_ALARM, b);
      chk("alarm flags", 16'(e[1]) << ch, 16'(b));
      rd_flag(A_WARN, b);
      chk("warn flags", 16'(e[0]) << ch, 16'(b));
      cyc(4);
      chk("interrupt cleared", 1'h1, interrupt_n);
    end
    $display("test flags done");
    power_down <= 1'b1;
    cyc(5);
    chk("standby", 1'h1, standby);
    chk("laser standby", 1'h0, laser_enable);
    power_down <= 1'b0;
    cyc(8);
    chk("laser in reset", 1'h0, laser_enable);
    cyc(20);
    chk("laser back", 1'h1, laser_enable);
    probe(DEV_ADDR, k);
    chk("ack after reset", 1'h0, k);
    $display("test power down done");
    end_sim();
  end
  initial begin
    cyc(40000);
    n_errors++;
    end_sim();
  end
endmodule
bind omc_top omc_checker u_chk (.mclk, .rst, .deselect, .laser_off_request,
  .power_down, .scl, .rx_no_light, .tx_lock_lost, .rx_lock_lost, .sda_oe,
  .interrupt_n, .not_ready_flag, .rx_signal_lost, .module_absent,
  .laser_enable, .standby);
